/* cvl_cfg_cell.sv */
// One volatile configuration byte with write-once bits
`timescale 1ns/1ns
module cvl_cfg_cell
  import cvl_pkg::*;
#(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  input  wire logic       ref_clk_i,
  input  wire logic       ce_i,
  input  wire logic       por_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_data_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] value_o,
  output logic      [7:0] lock_o
);

  cvl_cell_type st_q;
  cvl_cell_type st_d;
  logic [7:0]   wr_mask;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_d    = st_q;
    wr_mask = IMPL_MASK & ~st_q.lock;
    if (por_i) begin
      // RQ6 preset to ones
      st_d.val  = CVL_CELL_PRESET;
      st_d.lock = 8'h00;
    end else if (load_i) begin
      // RQ5 byte from its flash slot
      st_d.val  = (load_data_i & IMPL_MASK) | ~IMPL_MASK;
      st_d.lock = IMPL_MASK & ~load_data_i;
    end else if (wr_i) begin
      // RQ8 unlocked bits written once
      st_d.val  = (st_q.val & ~wr_mask) | (wr_data_i & wr_mask);
      st_d.lock = st_q.lock | wr_mask;
    end
  end

  // ==========================================================================
  // Storage
  // ==========================================================================
  // RQ3 plain flip-flops, lost at power-off
  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign value_o = st_q.val;
  assign lock_o  = st_q.lock;

endmodule

/* cvl_config_loader.sv */
// Configuration loader: copies stored configuration words into volatile bytes
//
// Summary of operation
// RQ1 - Programmed bit reads 0, unprogrammed reads 1
// RQ2 - Bytes sit at consecutive addresses from 300000h
// RQ3 - Configuration held in volatile cells only
// RQ4 - Hardware copies last four flash words after power-up
// RQ5 - Flash bytes F8h..FDh map onto 300000h..300005h
// RQ6 - Power-on reset forces every cell to one
// RQ7 - Other resets keep values, no reload
// RQ8 - Each bit written once per power cycle
// RQ9 - Flash image keeps upper nibbles of high bytes ones
// RQ10 - Ones in unimplemented upper bits change nothing
// RQ11 - Toolchain reserves configuration words at flash end
// RQ12 - Execution held until power-up load finishes
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module cvl_config_loader
  import cvl_pkg::*;
#(
  parameter int unsigned FLASH_AW    = 17,
  parameter int unsigned FLASH_BYTES = 131072
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  ce_i,
  input  wire logic                  por_i,
  output logic                       flash_rd_o,
  output logic      [FLASH_AW-1:0]   flash_addr_o,
  input  wire logic [7:0]            flash_data_i,
  input  wire logic [CVL_ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_we_i,
  input  wire logic                  reg_re_i,
  output logic      [7:0]            reg_rdata_o,
  output logic      [7:0]            cfg_byte_1_low_o,
  output logic      [7:0]            cfg_byte_1_high_o,
  output logic      [7:0]            cfg_byte_2_low_o,
  output logic      [7:0]            cfg_byte_2_high_o,
  output logic      [7:0]            cfg_byte_3_low_o,
  output logic      [7:0]            cfg_byte_3_high_o,
  output logic                       cpu_hold_o,
  output logic                       load_done_o
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (FLASH_BYTES % CVL_FCW_ALIGN != 0) begin : g_bad_align
    $error("Flash size must be a multiple of 256 bytes");
  end
  if (FLASH_BYTES < CVL_FCW_ALIGN || FLASH_AW > 31) begin : g_bad_size
    $error("Flash too small or address too wide");
  end
  if (FLASH_BYTES > (64'd1 << FLASH_AW)) begin : g_bad_aw
    $error("Flash size does not fit the address width");
  end
  if (FLASH_AW < 8) begin : g_bad_aw_min
    $error("Flash address narrower than one aligned page");
  end
  if (CVL_NUM_BYTES > (1 << CVL_IDX_W)) begin : g_bad_idx
    $error("Byte index too narrow for the byte count");
  end
  if (int'(CVL_LAST_IDX) != CVL_NUM_BYTES - 1) begin : g_bad_last
    $error("Last byte index does not match the byte count");
  end
  if (CVL_FCW_BYTES < CVL_NUM_BYTES) begin : g_bad_fcw
    $error("Stored words hold fewer bytes than the cells");
  end

  // ==========================================================================
  // Constants
  // ==========================================================================
  localparam logic [FLASH_AW-1:0] FCW_START =
    FLASH_AW'(FLASH_BYTES - CVL_FCW_BYTES);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic                por_meta;
    logic                por_sync;
    cvl_state_type       state;
    logic [CVL_IDX_W-1:0] idx;
    logic                flash_rd;
    logic [FLASH_AW-1:0] flash_addr;
    logic [7:0]          rdata;
    logic                hold;
    logic                done;
  } cvl_ctrl_type;

  cvl_ctrl_type st_q;
  cvl_ctrl_type st_d;

  logic [5:0]        cell_load;
  logic [5:0]        cell_wr;
  logic [5:0][7:0]   cell_val;
  logic [5:0][7:0]   cell_lock;
  logic              bus_ok;
  logic [7:0]        rd_mux;
  logic [7:0]        status_byte;

  // ==========================================================================
  // Configuration cells
  // ==========================================================================
  for (genvar i = 0; i < CVL_NUM_BYTES; i++) begin : g_cell
    cvl_cfg_cell #(
      .IMPL_MASK (CVL_IMPL_MASKS[i])
    ) u_cell (
      .ref_clk_i   (ref_clk_i),
      .ce_i        (ce_i),
      .por_i       (st_q.por_sync),
      .load_i      (cell_load[i]),
      .load_data_i (flash_data_i),
      .wr_i        (cell_wr[i]),
      .wr_data_i   (reg_wdata_i),
      .value_o     (cell_val[i]),
      .lock_o      (cell_lock[i])
    );
  end

  // ==========================================================================
  // Strobes into the cells
  // ==========================================================================
  // Bus access only once the load is complete and no reset is active
  assign bus_ok = st_q.done & ~st_q.por_sync & ~srst_i;

  always_comb begin
    cell_load = 6'h00;
    cell_wr   = 6'h00;
    // RQ4 capture each flash byte
    if (st_q.state == CVL_ST_CAP && !st_q.por_sync && !srst_i) begin
      cell_load[st_q.idx] = 1'b1;
    end
    // RQ8 writes reach only the addressed cell
    if (bus_ok && reg_we_i) begin
      case (reg_addr_i)
        CVL_OFS_1L: begin
          cell_wr[0] = 1'b1;
        end
        CVL_OFS_1H: begin
          cell_wr[1] = 1'b1;
        end
        CVL_OFS_2L: begin
          cell_wr[2] = 1'b1;
        end
        CVL_OFS_2H: begin
          cell_wr[3] = 1'b1;
        end
        CVL_OFS_3L: begin
          cell_wr[4] = 1'b1;
        end
        CVL_OFS_3H: begin
          cell_wr[5] = 1'b1;
        end
        default: begin
          cell_wr = 6'h00;
        end
      endcase
    end
  end

  // ==========================================================================
  // Read multiplexer
  // ==========================================================================
  always_comb begin
    status_byte = 8'h00;
    status_byte[CVL_STAT_DONE_BIT] = st_q.done;
    status_byte[CVL_STAT_BUSY_BIT] = st_q.hold;
    // RQ2 consecutive byte addresses
    // RQ1 stored bit value read as is
    // RQ10 unimplemented bits read zero
    case (reg_addr_i)
      CVL_OFS_1L: begin
        rd_mux = cell_val[0] & CVL_MASK_1L;
      end
      CVL_OFS_1H: begin
        rd_mux = cell_val[1] & CVL_MASK_1H;
      end
      CVL_OFS_2L: begin
        rd_mux = cell_val[2] & CVL_MASK_2L;
      end
      CVL_OFS_2H: begin
        rd_mux = cell_val[3] & CVL_MASK_2H;
      end
      CVL_OFS_3L: begin
        rd_mux = cell_val[4] & CVL_MASK_3L;
      end
      CVL_OFS_3H: begin
        rd_mux = cell_val[5] & CVL_MASK_3H;
      end
      CVL_OFS_STATUS: begin
        rd_mux = status_byte;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // ==========================================================================
  // Loader sequence and bus answer
  // ==========================================================================
  always_comb begin
    st_d          = st_q;
    st_d.por_meta = por_i;
    st_d.por_sync = st_q.por_meta;
    st_d.flash_rd = 1'b0;
    st_d.rdata    = 8'h00;

    if (st_q.por_sync) begin
      // RQ6 restart from preset cells
      st_d.state = CVL_ST_IDLE;
      st_d.idx   = '0;
      st_d.hold  = 1'b1;
      st_d.done  = 1'b0;
    end else if (srst_i) begin
      // RQ7 finished load survives reset
      if (!st_q.done) begin
        st_d.state = CVL_ST_IDLE;
        st_d.idx   = '0;
      end
      st_d.hold = ~st_q.done;
    end else begin
      if (reg_re_i && st_q.done) begin
        st_d.rdata = rd_mux;
      end

      case (st_q.state)
        CVL_ST_IDLE: begin
          // RQ12 core held during load
          st_d.hold  = 1'b1;
          st_d.state = CVL_ST_REQ;
        end
        CVL_ST_REQ: begin
          // RQ5 slot address from flash end
          st_d.flash_rd   = 1'b1;
          st_d.flash_addr = FCW_START + FLASH_AW'(st_q.idx);
          st_d.state      = CVL_ST_WAIT;
        end
        CVL_ST_WAIT: begin
          st_d.state = CVL_ST_CAP;
        end
        CVL_ST_CAP: begin
          if (st_q.idx == CVL_LAST_IDX) begin
            // RQ12 release core after last byte
            st_d.state = CVL_ST_DONE;
            st_d.done  = 1'b1;
            st_d.hold  = 1'b0;
          end else begin
            st_d.idx   = st_q.idx + 3'h1;
            st_d.state = CVL_ST_REQ;
          end
        end
        CVL_ST_DONE: begin
          st_d.hold = 1'b0;
        end
        default: begin
          st_d.state = CVL_ST_IDLE;
          st_d.idx   = '0;
          st_d.hold  = 1'b1;
          st_d.done  = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Power-on state comes from the synchronised power-on input
  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign flash_rd_o        = st_q.flash_rd;
  assign flash_addr_o      = st_q.flash_addr;
  assign reg_rdata_o       = st_q.rdata;
  assign cpu_hold_o        = st_q.hold;
  assign load_done_o       = st_q.done;
  assign cfg_byte_1_low_o  = cell_val[0];
  assign cfg_byte_1_high_o = cell_val[1];
  assign cfg_byte_2_low_o  = cell_val[2];
  assign cfg_byte_2_high_o = cell_val[3];
  assign cfg_byte_3_low_o  = cell_val[4];
  assign cfg_byte_3_high_o = cell_val[5];

endmodule

/* cvl_config_loader_asserts.sv */
// Port checker for the configuration loader
`timescale 1ns/1ns
module cvl_config_loader_asserts
  import cvl_pkg::*;
#(
  parameter int unsigned FLASH_AW    = 17,
  parameter int unsigned FLASH_BYTES = 131072
) (
  input wire logic                  ref_clk_i,
  input wire logic                  srst_i,
  input wire logic                  por_i,
  input wire logic                  flash_rd_o,
  input wire logic [FLASH_AW-1:0]   flash_addr_o,
  input wire logic [CVL_ADDR_W-1:0] reg_addr_i,
  input wire logic                  reg_we_i,
  input wire logic                  reg_re_i,
  input wire logic [7:0]            reg_rdata_o,
  input wire logic [7:0]            cfg_byte_1_low_o,
  input wire logic [7:0]            cfg_byte_1_high_o,
  input wire logic [7:0]            cfg_byte_3_high_o,
  input wire logic                  cpu_hold_o,
  input wire logic                  load_done_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (por_i);
  // ==========================================================================
  // Assertions
  chk_rd_space: assert property (
    flash_rd_o |=> !flash_rd_o [*2])
    else $error("flash reads closer than three cycles");
  chk_rd_window: assert property (
    flash_rd_o |-> int'(flash_addr_o) >= FLASH_BYTES - 8
      && int'(flash_addr_o) < FLASH_BYTES - 2)
    else $error("flash read outside stored words");
  chk_addr_step: assert property (
    flash_rd_o && !srst_i ##3 flash_rd_o |-> flash_addr_o == $past(flash_addr_o, 3) + 1'b1)
    else $error("flash addresses not ascending");
  chk_load_time: assert property (
    $fell(por_i) |-> !load_done_o ##[15:30] load_done_o)
    else $error("power-up load not finished in time");
  chk_no_reload: assert property (
    load_done_o |-> !flash_rd_o)
    else $error("flash read after load finished");
  chk_srst_keep: assert property (
    load_done_o && srst_i |=> load_done_o && $stable(cfg_byte_1_low_o)
      && $stable(cfg_byte_3_high_o))
    else $error("device reset changed loaded bytes");
  chk_por_preset: assert property (disable iff (srst_i)
    por_i [*5] |-> cfg_byte_1_low_o == 8'hFF && cfg_byte_1_high_o == 8'hFF
      && !load_done_o)
    else $error("power-on reset did not preset cells");
  chk_hold_exec: assert property (
    !load_done_o |-> cpu_hold_o)
    else $error("execution released before load done");
  chk_upper_ones: assert property (
    !srst_i |-> (cfg_byte_1_high_o | 8'h04) == 8'hFF)
    else $error("unimplemented bits changed");
  chk_rsvd_read: assert property (
    reg_re_i && reg_addr_i == 22'h300004 |=> reg_rdata_o == 8'h00)
    else $error("reserved byte read not zero");
  cover property ($rose(load_done_o));
  cover property (reg_we_i && load_done_o);
  cover property (srst_i && load_done_o);
endmodule

bind cvl_config_loader cvl_config_loader_asserts #(
  .FLASH_AW(FLASH_AW),
  .FLASH_BYTES(FLASH_BYTES)
) u_chk (.ref_clk_i, .srst_i, .por_i, .flash_rd_o, .flash_addr_o, .reg_addr_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o, .cfg_byte_1_low_o, .cfg_byte_1_high_o,
  .cfg_byte_3_high_o, .cpu_hold_o, .load_done_o);

/* cvl_flash_model.sv */
// Program flash model with stored configuration words at its end
`timescale 1ns/1ns
module cvl_flash_model #(
  parameter int unsigned AW    = 8,
  parameter int unsigned BYTES = 256
) (
  input  wire logic          ref_clk_i,
  input  wire logic          flash_rd_i,
  input  wire logic [AW-1:0] flash_addr_i,
  output logic      [7:0]    flash_data_o
);
  logic [7:0] mem [BYTES];
  // ==========================================================================
  // Contents
  // code kept out of last words
  initial begin
    for (int i = 0; i < BYTES; i++) begin
      mem[i] = (i < BYTES - 8) ? 8'(i) : 8'hFF;
    end
    flash_data_o = 8'h5A;
  end
  always @(posedge ref_clk_i) begin
    if (flash_rd_i) begin
      flash_data_o <= mem[flash_addr_i];
    end else begin
      flash_data_o <= ~flash_data_o;
    end
  end
endmodule

/* cvl_pkg.sv */
// Constants and types shared by the configuration loader files
package cvl_pkg;

  // ==========================================================================
  // Address space
  // ==========================================================================
  localparam int unsigned CVL_ADDR_W     = 22;
  localparam int unsigned CVL_NUM_BYTES  = 6;
  localparam int unsigned CVL_IDX_W      = 3;
  localparam logic [21:0] CVL_OFS_1L     = 22'h300000;
  localparam logic [21:0] CVL_OFS_1H     = 22'h300001;
  localparam logic [21:0] CVL_OFS_2L     = 22'h300002;
  localparam logic [21:0] CVL_OFS_2H     = 22'h300003;
  localparam logic [21:0] CVL_OFS_3L     = 22'h300004;
  localparam logic [21:0] CVL_OFS_3H     = 22'h300005;
  localparam logic [21:0] CVL_OFS_STATUS = 22'h300008;

  // ==========================================================================
  // Stored configuration words in flash
  // ==========================================================================
  localparam int unsigned CVL_FCW_BYTES  = 8;
  localparam int unsigned CVL_FCW_ALIGN  = 256;
  localparam logic [2:0]  CVL_LAST_IDX   = 3'h5;

  // ==========================================================================
  // Cell layout and values
  // ==========================================================================
  localparam logic [7:0] CVL_CELL_PRESET = 8'hFF;
  localparam logic [7:0] CVL_MASK_1L     = 8'hE1;
  localparam logic [7:0] CVL_MASK_1H     = 8'h04;
  localparam logic [7:0] CVL_MASK_2L     = 8'hC7;
  localparam logic [7:0] CVL_MASK_2H     = 8'h0F;
  localparam logic [7:0] CVL_MASK_3L     = 8'h00;
  localparam logic [7:0] CVL_MASK_3H     = 8'h01;
  localparam logic [5:0][7:0] CVL_IMPL_MASKS = {
    CVL_MASK_3H, CVL_MASK_3L, CVL_MASK_2H, CVL_MASK_2L, CVL_MASK_1H, CVL_MASK_1L
  };
  localparam int unsigned CVL_STAT_DONE_BIT = 0;
  localparam int unsigned CVL_STAT_BUSY_BIT = 1;

  // ==========================================================================
  // Loader states
  // ==========================================================================
  typedef enum logic [4:0] {
    CVL_ST_IDLE = 5'b00001,
    CVL_ST_REQ  = 5'b00010,
    CVL_ST_WAIT = 5'b00100,
    CVL_ST_CAP  = 5'b01000,
    CVL_ST_DONE = 5'b10000
  } cvl_state_type;

  typedef struct packed {
    logic [7:0] val;
    logic [7:0] lock;
  } cvl_cell_type;

endpackage

/* tb_top.sv */
// Testbench for the configuration loader
`timescale 1ns/1ns
module tb_top
  import cvl_pkg::*;
;
  localparam int unsigned FB = 256;
  logic                  ref_clk_i;
  logic                  srst_i;
  logic                  ce_i;
  logic                  por_i;
  logic                  reg_we_i;
  logic                  reg_re_i;
  logic [7:0]            reg_wdata_i;
  logic [CVL_ADDR_W-1:0] reg_addr_i;
  logic                  flash_rd;
  logic [7:0]            flash_addr;
  logic [7:0]            flash_data;
  logic [7:0]            rdata;
  logic                  hold;
  logic                  done;
  logic [5:0][7:0]       cfg;
  logic [5:0][7:0]       img;
  int                    bad_count;
  int                    checked;
  int                    cyc;

  cvl_config_loader #(.FLASH_AW(8), .FLASH_BYTES(FB)) uut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i), .por_i(por_i),
    .flash_rd_o(flash_rd), .flash_addr_o(flash_addr), .flash_data_i(flash_data),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(rdata),
    .cfg_byte_1_low_o(cfg[0]), .cfg_byte_1_high_o(cfg[1]),
    .cfg_byte_2_low_o(cfg[2]), .cfg_byte_2_high_o(cfg[3]),
    .cfg_byte_3_low_o(cfg[4]), .cfg_byte_3_high_o(cfg[5]),
    .cpu_hold_o(hold), .load_done_o(done));
  cvl_flash_model #(.AW(8), .BYTES(FB)) u_flash (
    .ref_clk_i(ref_clk_i), .flash_rd_i(flash_rd), .flash_addr_i(flash_addr),
    .flash_data_o(flash_data));

  always #10 ref_clk_i = ~ref_clk_i;
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [21:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_re_i <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic put_img();
    for (int k = 0; k < 6; k++) begin
      u_flash.mem[FB-8+k] = img[k];
    end
  endtask
  task automatic por_load();
    @(posedge ref_clk_i);
    por_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    por_i <= 1'b0;
    #1 chk({7'h0, hold}, 8'h01);
    for (int k = 0; k < 6; k++) begin
      chk(cfg[k], 8'hFF);
    end
    for (int n = 0; n < 60 && done !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk({7'h0, done}, 8'h01);
    for (int k = 0; k < 6; k++) begin
      rd(CVL_OFS_1L + 22'(k), img[k] & CVL_IMPL_MASKS[k]);
      chk(cfg[k], img[k] | ~CVL_IMPL_MASKS[k]);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  // ==========================================================================
  // Tests
  initial begin
    ref_clk_i   = 1'b0;
    srst_i      = 1'b1;
    ce_i        = 1'b1;
    por_i       = 1'b1;
    reg_we_i    = 1'b0;
    reg_re_i    = 1'b0;
    reg_addr_i  = '0;
    reg_wdata_i = 8'h00;
    bad_count   = 0;
    checked     = 0;
    cyc         = 0;
    // upper nibbles of high bytes kept ones
    img = {8'hFF, 8'h00, 8'hF5, 8'hFA, 8'hFB, 8'hFE};
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    put_img();
    por_load();
    rd(CVL_OFS_STATUS, 8'h01);
    rd(22'h300006, 8'h00);
    chk({7'h0, hold}, 8'h00);
    $display("test power-up load done");
    wr(CVL_OFS_1L, 8'h00);
    rd(CVL_OFS_1L, 8'h00);
    wr(CVL_OFS_1L, 8'hFF);
    rd(CVL_OFS_1L, 8'h00);
    wr(CVL_OFS_2H, 8'hFF);
    wr(CVL_OFS_2H, 8'h00);
    rd(CVL_OFS_2H, 8'h05);
    wr(CVL_OFS_1H, 8'hF0);
    rd(CVL_OFS_1H, 8'h00);
    chk(cfg[1], 8'hFB);
    $display("test write-once done");
    // Write with clock enable low must not land
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    wr(CVL_OFS_2L, 8'h00);
    ce_i <= 1'b1;
    rd(CVL_OFS_2L, 8'hFA & CVL_MASK_2L);
    $display("test clock enable done");
    img[0] = 8'h7F;
    img[2] = 8'hF9;
    put_img();
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    @(posedge ref_clk_i);
    srst_i <= 1'b0;
    repeat (30) @(posedge ref_clk_i);
    #1 chk({7'h0, done}, 8'h01);
    rd(CVL_OFS_1L, 8'h00);
    rd(CVL_OFS_2L, 8'hFA & CVL_MASK_2L);
    $display("test device reset done");
    por_load();
    $display("test power cycle done");
    stop_test();
  end
endmodule
